// ==== hw/lpt_pkg.sv ====
/*
 lpt_pkg: constants and carrier types for the lower-order path trail
 termination (vc-12 / vc-11 containers).
 assumes: 50 mhz system clock, apb register access, 32-bit data.
*/
`default_nettype none
package lpt_pkg;
   // ==========================================================
   // container geometry
   localparam logic [7:0] VC12_POH_OCTETS = 8'h04;
   localparam logic [7:0] VC12_PAY_OCTETS = 8'h88;   // 136
   localparam logic [7:0] VC11_PAY_OCTETS = 8'h64;   // 100
   // poh bytes sit one per quarter of the multiframe
   localparam logic [7:0] VC12_QUARTER = 8'((VC12_PAY_OCTETS + VC12_POH_OCTETS) / 4);
   localparam logic [7:0] VC11_QUARTER = 8'((VC11_PAY_OCTETS + VC12_POH_OCTETS) / 4);
   // v5 field positions, transmission bit 1 is the msb
   localparam int V5_BIP_HI = 7;
   localparam int V5_BIP_LO = 6;
   localparam int V5_REI    = 5;
   localparam int V5_RFI    = 4;
   localparam int V5_SL_HI  = 3;
   localparam int V5_SL_LO  = 1;
   localparam int V5_RDI    = 0;
   localparam logic [2:0] SL_UNEQUIPPED = 3'h0;
   // ==========================================================
   // timing
   localparam longint CLK_PERIOD_NS = 64'd20;
   localparam longint PM_PERIOD_NS  = 64'd1000000000;
   localparam longint PM_PERIOD_CYC = PM_PERIOD_NS / CLK_PERIOD_NS;
   // ==========================================================
   // register map (byte offsets) and reset values
   localparam logic [11:0] REG_CTRL      = 12'h000;
   localparam logic [11:0] REG_TX_TRACE  = 12'h004;
   localparam logic [11:0] REG_EXP_TRACE = 12'h008;
   localparam logic [11:0] REG_STATUS    = 12'h00c;
   localparam logic [11:0] REG_PM_NEAR   = 12'h010;
   localparam logic [11:0] REG_PM_FAR    = 12'h014;
   localparam int CTRL_VC11 = 0;
   localparam int CTRL_UNI  = 1;
   localparam int CTRL_MONITOR = 2;
   localparam logic [2:0] CTRL_RST  = 3'h0;
   localparam logic [7:0] TRACE_RST = 8'h00;
   localparam logic [15:0] CNT_MAX  = 16'hffff;
   // ==========================================================
   // container byte carrier
   typedef struct packed {
      logic       valid;
      logic       mfstart;   // marks the v5 byte
      logic [7:0] data;
   } lpt_byte_t;
endpackage
`default_nettype wire

// ==== hw/lpt_path_term.sv ====
/*
 lpt_path_term: lower-order path trail termination, transmit overhead
 insertion, receive overhead checks and one-second performance counts.
 assumes: neighbouring logic on sys_clk delivers container bytes with a
 valid strobe and a multiframe-start marker on the v5 byte; no stall.
*/
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module lpt_path_term
   import lpt_pkg::*;
#(
   parameter int unsigned SEC_CYC = 32'(PM_PERIOD_CYC)
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // transmit stream
   input  wire lpt_byte_t   tx_in,
   output var  lpt_byte_t   tx_out_r,
   // receive stream
   input  wire lpt_byte_t   rx_in,
   // equipment manager reports
   output var  logic        trace_mismatch_defect_r,
   output var  logic        unequipped_defect_r,
   output var  logic        pm_report_r,
   output var  logic [15:0] near_errored_block_count_r,
   output var  logic        near_defect_second_r,
   output var  logic [15:0] far_errored_block_count_r,
   output var  logic        far_defect_second_r
);
   // ==========================================================
   // helpers
   function automatic logic [1:0] bip_of(input logic [7:0] d);
      return {d[7] ^ d[5] ^ d[3] ^ d[1], d[6] ^ d[4] ^ d[2] ^ d[0]};
   endfunction

   function automatic logic [15:0] sat_add(input logic [15:0] c, input logic e);
      return (c == CNT_MAX) ? c : c + {15'h0, e};
   endfunction

   // ==========================================================
   // configuration registers
   logic        cfg_vc11_r;
   logic        cfg_uni_r;
   logic        monitored_state_r;
   logic [7:0]  tx_trace_r;
   logic [7:0]  expected_trace_identifier_r;
   logic [7:0]  quarter_c;
   logic        apb_wr_c;
   logic [31:0] rd_c;
   logic        rd_err_c;
   logic        mismatch_r;
   logic        unequip_r;
   logic        rdi_r;

   // poh spacing follows the container size
   assign quarter_c = cfg_vc11_r ? VC11_QUARTER : VC12_QUARTER;

   // ==========================================================
   // apb slave: no wait state, answer in the first access cycle
   assign apb_wr_c = psel & penable & pready & pwrite;

   // read mux and unmapped decode
   always_comb begin
      rd_c     = 32'h0;
      rd_err_c = 1'b0;
      unique case (paddr)
         REG_CTRL:      rd_c = {29'h0, monitored_state_r, cfg_uni_r, cfg_vc11_r};
         REG_TX_TRACE:  rd_c = {24'h0, tx_trace_r};
         REG_EXP_TRACE: rd_c = {24'h0, expected_trace_identifier_r};
         REG_STATUS:    rd_c = {28'h0, rdi_r, unequip_r, mismatch_r, cfg_uni_r};
         REG_PM_NEAR:   rd_c = {15'h0, near_defect_second_r, near_errored_block_count_r};
         REG_PM_FAR:    rd_c = {15'h0, far_defect_second_r, far_errored_block_count_r};
         default:       rd_err_c = 1'b1;
      endcase
   end

   // handshake; pready rises only after a setup cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel & ~penable & ~pready;
         pslverr <= psel & ~penable & ~pready & rd_err_c;
         prdata  <= (psel & ~penable & ~pwrite & ~rd_err_c) ? rd_c : 32'h0;
      end
   end

   // configuration writes take effect at the completing edge
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cfg_vc11_r                  <= CTRL_RST[CTRL_VC11];
         cfg_uni_r                   <= CTRL_RST[CTRL_UNI];
         monitored_state_r           <= CTRL_RST[CTRL_MONITOR];
         tx_trace_r                  <= TRACE_RST;
         expected_trace_identifier_r <= TRACE_RST;
      end else if (apb_wr_c) begin
         if (paddr == REG_CTRL) begin
            cfg_vc11_r        <= pwdata[CTRL_VC11];
            cfg_uni_r         <= pwdata[CTRL_UNI];
            monitored_state_r <= pwdata[CTRL_MONITOR];
         end
         if (paddr == REG_TX_TRACE)
            tx_trace_r <= pwdata[7:0];
         if (paddr == REG_EXP_TRACE)
            expected_trace_identifier_r <= pwdata[7:0];
      end
   end

   // ==========================================================
   // transmit: overhead insertion
   logic [7:0] tx_pos_r;
   logic [1:0] tx_bip_r;
   logic       rei_pend_r;
   logic       tx_j2_c;
   logic [7:0] tx_byte_c;
   logic       near_ev_r;

   // j2 is located by counting from the marked v5 byte
   assign tx_j2_c = tx_in.valid & ~tx_in.mfstart & (tx_pos_r == quarter_c);

   // outgoing byte; k4, n2 and rfi left as zero/passed
   always_comb begin
      tx_byte_c = tx_in.data;
      if (tx_in.mfstart) begin
         tx_byte_c[V5_BIP_HI:V5_BIP_LO] = tx_bip_r;
         tx_byte_c[V5_REI] = cfg_uni_r ? 1'b0 : rei_pend_r;
         tx_byte_c[V5_RFI] = 1'b0;
         tx_byte_c[V5_RDI] = cfg_uni_r ? 1'b0 : (mismatch_r | unequip_r);
      end else if (tx_j2_c) begin
         tx_byte_c = tx_trace_r;
      end
   end

   // byte position within the outgoing multiframe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         tx_pos_r <= 8'h0;
      else if (tx_in.valid)
         tx_pos_r <= tx_in.mfstart ? 8'h1 : tx_pos_r + 8'h1;
   end

   // bip-2 over what is actually sent, v5 included
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         tx_bip_r <= 2'h0;
      else if (tx_in.valid)
         tx_bip_r <= tx_in.mfstart ? bip_of(tx_byte_c) : tx_bip_r ^ bip_of(tx_byte_c);
   end

   // rei waits for the next v5; a new error beats the clear
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         rei_pend_r <= 1'b0;
      else if (near_ev_r)
         rei_pend_r <= 1'b1;
      else if (tx_in.valid & tx_in.mfstart)
         rei_pend_r <= 1'b0;
   end

   // registered output; label bits pass untouched
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         tx_out_r <= '0;
      else
         tx_out_r <= '{valid: tx_in.valid, mfstart: tx_in.mfstart, data: tx_byte_c};
   end

   // ==========================================================
   // receive: overhead checks
   logic [7:0] rx_pos_r;
   logic [1:0] rx_bip_r;
   logic       rx_prev_r;
   logic       rx_v5_c;
   logic       rx_j2_c;
   logic       far_ev_r;

   assign rx_v5_c = rx_in.valid & rx_in.mfstart;
   assign rx_j2_c = rx_in.valid & ~rx_in.mfstart & (rx_pos_r == quarter_c);

   // position and running parity; k4, n2, rfi only feed the parity
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rx_pos_r  <= 8'h0;
         rx_bip_r  <= 2'h0;
         rx_prev_r <= 1'b0;
      end else if (rx_in.valid) begin
         rx_pos_r  <= rx_in.mfstart ? 8'h1 : rx_pos_r + 8'h1;
         rx_bip_r  <= rx_in.mfstart ? bip_of(rx_in.data) : rx_bip_r ^ bip_of(rx_in.data);
         rx_prev_r <= rx_prev_r | rx_in.mfstart;
      end
   end

   // errored block: first multiframe has no reference and is skipped
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         near_ev_r <= 1'b0;
         far_ev_r  <= 1'b0;
      end else begin
         near_ev_r <= rx_v5_c & rx_prev_r &
                      (rx_in.data[V5_BIP_HI:V5_BIP_LO] != rx_bip_r);
         far_ev_r  <= rx_v5_c & ~cfg_uni_r & rx_in.data[V5_REI];
      end
   end

   // defect states update on their own overhead byte
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mismatch_r <= 1'b0;
         unequip_r  <= 1'b0;
         rdi_r      <= 1'b0;
      end else begin
         if (rx_j2_c)
            mismatch_r <= (rx_in.data != expected_trace_identifier_r);
         if (rx_v5_c) begin
            unequip_r <= (rx_in.data[V5_SL_HI:V5_SL_LO] == SL_UNEQUIPPED);
            rdi_r     <= ~cfg_uni_r & rx_in.data[V5_RDI];
         end
         if (cfg_uni_r)
            rdi_r <= 1'b0;
      end
   end

   // defects reach the manager only in the monitored state
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         trace_mismatch_defect_r <= 1'b0;
         unequipped_defect_r     <= 1'b0;
      end else begin
         trace_mismatch_defect_r <= mismatch_r & monitored_state_r;
         unequipped_defect_r     <= unequip_r & monitored_state_r;
      end
   end

   // ==========================================================
   // one-second performance filter
   logic [31:0] sec_cnt_r;
   logic        tick_c;
   logic [15:0] near_cnt_r;
   logic [15:0] far_cnt_r;
   logic        near_ds_r;
   logic        far_ds_r;

   assign tick_c = (sec_cnt_r == 32'(SEC_CYC - 1));

   // free-running divider; a parameter so simulation can shorten it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         sec_cnt_r <= 32'h0;
      else
         sec_cnt_r <= tick_c ? 32'h0 : sec_cnt_r + 32'h1;
   end

   // accumulators; at the boundary the event of that cycle goes into
   // the report and the fresh interval starts at zero, so none is lost
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         near_cnt_r <= 16'h0;
         far_cnt_r  <= 16'h0;
         near_ds_r  <= 1'b0;
         far_ds_r   <= 1'b0;
      end else if (tick_c) begin
         near_cnt_r <= 16'h0;
         far_cnt_r  <= 16'h0;
         near_ds_r  <= 1'b0;
         far_ds_r   <= 1'b0;
      end else begin
         near_cnt_r <= sat_add(near_cnt_r, near_ev_r);
         near_ds_r  <= near_ds_r | mismatch_r | unequip_r;
         far_cnt_r  <= cfg_uni_r ? 16'h0 : sat_add(far_cnt_r, far_ev_r);
         far_ds_r   <= ~cfg_uni_r & (far_ds_r | rdi_r);
      end
   end

   // report latch; results refresh only while monitored
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pm_report_r                <= 1'b0;
         near_errored_block_count_r <= 16'h0;
         near_defect_second_r       <= 1'b0;
         far_errored_block_count_r  <= 16'h0;
         far_defect_second_r        <= 1'b0;
      end else begin
         pm_report_r <= tick_c & monitored_state_r;
         if (tick_c & monitored_state_r) begin
            near_errored_block_count_r <= sat_add(near_cnt_r, near_ev_r);
            near_defect_second_r       <= near_ds_r | mismatch_r | unequip_r;
            far_errored_block_count_r  <= cfg_uni_r ? 16'h0 : sat_add(far_cnt_r, far_ev_r);
            far_defect_second_r        <= ~cfg_uni_r & (far_ds_r | rdi_r);
         end
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_v5_sent;
      tx_out_r.valid && tx_out_r.mfstart;
   endsequence

   sequence s_apb_setup;
      psel && !penable && !pready;
   endsequence

   tx_uni_zero_a: assert property (s_v5_sent and $past(cfg_uni_r) |->
      !tx_out_r.data[V5_REI] && !tx_out_r.data[V5_RDI])
      else $error("rei or rdi sent in unidirectional mode");

   tx_label_pass_a: assert property (s_v5_sent |->
      tx_out_r.data[V5_SL_HI:V5_SL_LO] == $past(tx_in.data[V5_SL_HI:V5_SL_LO]))
      else $error("signal label altered on transmit");

   tx_trace_ins_a: assert property ($past(tx_j2_c) |->
      tx_out_r.data == $past(tx_trace_r))
      else $error("j2 not the configured trace");

   tx_bip_ins_a: assert property (tx_in.valid && tx_in.mfstart |=>
      tx_out_r.data[V5_BIP_HI:V5_BIP_LO] == $past(tx_bip_r))
      else $error("bip-2 not inserted in v5");

   rx_bip_err_a: assert property (rx_v5_c && rx_prev_r &&
      rx_in.data[V5_BIP_HI:V5_BIP_LO] != rx_bip_r |=> near_ev_r)
      else $error("parity violation not counted");

   rx_rei_uni_a: assert property (cfg_uni_r && $past(cfg_uni_r) |-> !far_ev_r)
      else $error("rei used in unidirectional mode");

   rx_trace_rep_a: assert property (trace_mismatch_defect_r |-> $past(monitored_state_r))
      else $error("trace mismatch reported outside monitored state");

   pm_report_a: assert property (tick_c && monitored_state_r |=>
      pm_report_r ##1 !pm_report_r)
      else $error("report pulse wrong");

   pm_far_uni_a: assert property (pm_report_r && $past(cfg_uni_r) |->
      far_errored_block_count_r == 16'h0 && !far_defect_second_r)
      else $error("far-end results in unidirectional mode");

   pm_no_loss_a: assert property (tick_c && monitored_state_r && near_cnt_r != CNT_MAX |=>
      near_errored_block_count_r == $past(near_cnt_r) + 16'($past(near_ev_r)) &&
      near_cnt_r == 16'h0)
      else $error("boundary event lost or doubled");

   apb_answer_a: assert property (s_apb_setup |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

endmodule // lpt_path_term
`default_nettype wire

// ==== test/lpt_stream_model.sv ====
/*
 lpt_stream_model: neighbouring stream logic that sends containers on
 both streams and watches the overhead that the block transmits.
 assumes: one sys_clk domain; the bench calls send_mf, one at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module lpt_stream_model
   import lpt_pkg::*;
(
   input  wire logic      sys_clk,
   input  wire lpt_byte_t tx_out_r,
   output var  lpt_byte_t tx_in,
   output var  lpt_byte_t rx_in
);
   logic [1:0] rx_acc  = 2'h0;
   logic [1:0] tx_acc  = 2'h0;
   logic [1:0] tx_bip  = 2'h0;
   logic [7:0] last_v5 = 8'h00;
   logic [7:0] last_j2 = 8'h00;
   int         qtr     = 35;
   int         idx     = 0;

   initial begin
      tx_in = '0;
      rx_in = '0;
   end

   // ==========================================================
   // pair parity of one byte, transmission bit 1 is the msb
   function automatic logic [1:0] bp(input logic [7:0] b);
      return {b[7] ^ b[5] ^ b[3] ^ b[1], b[6] ^ b[4] ^ b[2] ^ b[0]};
   endfunction

   // ==========================================================
   // one multiframe on both streams; tx prediction holds for one-way mode only
   task automatic send_mf(input logic v11, input logic [2:0] lbl, input logic [7:0] j2,
                          input logic [7:0] trc, input logic err, input logic rei,
                          input logic rdi, input logic gap);
      int         n;
      int         i;
      logic [7:0] r;
      logic [7:0] t;
      logic [7:0] te;
      n = v11 ? int'(VC11_PAY_OCTETS) + 4 : int'(VC12_PAY_OCTETS) + 4;
      qtr = n / 4;
      for (i = 0; i < n; i++) begin
         t = (i == 0) ? 8'hf3 : (i == qtr) ? 8'hff : 8'(i * 7 + 3);
         r = 8'(i * 5 + 1);
         te = t;
         if (i == 0) begin
            r = {rx_acc ^ {1'b0, err}, rei, 1'b1, lbl, rdi};
            te = {tx_acc, 6'h02};
            tx_bip = tx_acc;
            rx_acc = 2'h0;
            tx_acc = 2'h0;
         end
         if (i == qtr) begin
            r = j2;
            te = trc;
         end
         rx_acc = rx_acc ^ bp(r);
         tx_acc = tx_acc ^ bp(te);
         @(posedge sys_clk);
         tx_in <= '{1'b1, i == 0, t};
         rx_in <= '{1'b1, i == 0, r};
         if (gap) begin
            @(posedge sys_clk);
            tx_in <= '{1'b0, 1'b0, ~t};
            rx_in <= '{1'b0, 1'b0, ~r};
         end
      end
      // idle lines show the inverse, never a stale byte
      @(posedge sys_clk);
      tx_in <= '{1'b0, 1'b0, ~t};
      rx_in <= '{1'b0, 1'b0, ~r};
   endtask

   // ==========================================================
   // far-side capture of the inserted v5 and j2
   always @(posedge sys_clk) begin
      if (tx_out_r.valid === 1'b1) begin
         if (tx_out_r.mfstart === 1'b1) begin
            last_v5 <= tx_out_r.data;
            idx <= 1;
         end else begin
            if (idx == qtr) last_j2 <= tx_out_r.data;
            idx <= idx + 1;
         end
      end
   end
endmodule // lpt_stream_model
`default_nettype wire

// ==== test/tb.sv ====
/*
 tb: register tasks over apb and overhead scenarios for lpt_path_term.
 assumes: lpt_stream_model feeds both streams; short second of SEC cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module tb
   import lpt_pkg::*;
;
   localparam int unsigned SEC = 1000;
   localparam logic [31:0] UNI = 32'h1 << CTRL_UNI;
   localparam logic [31:0] WCH = 32'h1 << CTRL_MONITOR;
   localparam logic [31:0] V11 = 32'h1 << CTRL_VC11;
   logic        sys_clk = 1'b0;
   logic        nrst    = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, rv, sn, sf;
   logic        pready, pslverr, re, mis, unq, pm, nds, fds, dn, df;
   logic [15:0] ncnt, fcnt;
   lpt_byte_t   tx_in, tx_out, rx_in;
   logic        v11 = 1'b0;
   logic        gp  = 1'b0;
   logic [7:0]  trc = 8'h00;
   int          fail_count = 0;
   int          n_checks   = 0;
   int          nrep = 0;
   int          cyc  = 0;

   always #10 sys_clk = ~sys_clk;

   lpt_path_term #(.SEC_CYC(SEC)) uut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tx_in, .tx_out_r(tx_out), .rx_in,
      .trace_mismatch_defect_r(mis), .unequipped_defect_r(unq), .pm_report_r(pm),
      .near_errored_block_count_r(ncnt), .near_defect_second_r(nds),
      .far_errored_block_count_r(fcnt), .far_defect_second_r(fds));

   lpt_stream_model u_src (.sys_clk, .tx_out_r(tx_out), .tx_in, .rx_in);

   // ==========================================================
   // comparison and verdict
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ==========================================================
   // apb master: request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      chk("apb wait", k, 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rv, exp);
   endtask

   task automatic mf(input logic [2:0] l, input logic [7:0] j, input logic e,
                     input logic ri, input logic rd);
      u_src.send_mf(v11, l, j, trc, e, ri, rd, gp);
   endtask

   // results summed over every report so that boundaries do not matter
   always @(posedge sys_clk) begin
      if (pm === 1'b1) begin
         nrep++;
         sn = sn + ncnt;
         sf = sf + fcnt;
         dn = dn | nds;
         df = df | fds;
      end
   end

   task automatic clr;
      nrep = 0;
      sn = 32'h0;
      sf = 32'h0;
      dn = 1'b0;
      df = 1'b0;
   endtask

   // run guard; a hung wait ends here
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         close_out();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      clr();
      repeat (12) @(posedge sys_clk);
      chk("reset flags", {tx_out, mis, unq, pm, nds, fds}, 32'h0);
      chk("reset counts", {ncnt, fcnt}, 32'h0);
      nrst <= 1'b1;
      rdc("ctrl", REG_CTRL, 32'(CTRL_RST));
      rdc("tx trace", REG_TX_TRACE, 32'(TRACE_RST));
      rdc("exp trace", REG_EXP_TRACE, 32'(TRACE_RST));
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped err", re, 32'h1);
      chk("unmapped data", rv, 32'h0);
      apb(1'b1, REG_STATUS, 32'hf);
      rdc("status ro", REG_STATUS, 32'h0);
      // one-way path: inserted trace, zero rei and rdi, bip chain
      apb(1'b1, REG_CTRL, UNI);
      trc = 8'h5a;
      apb(1'b1, REG_TX_TRACE, 32'h5a);
      mf(3'h1, 8'h00, 1'b0, 1'b1, 1'b1);
      mf(3'h1, 8'h00, 1'b0, 1'b1, 1'b1);
      chk("tx j2", u_src.last_j2, 32'h5a);
      chk("tx rei rdi", {u_src.last_v5[5], u_src.last_v5[0]}, 32'h0);
      chk("tx label", u_src.last_v5[3:1], 32'h1);
      chk("tx bip", u_src.last_v5[7:6], u_src.tx_bip);
      rdc("status uni", REG_STATUS, 32'h1);
      // monitored two-way path: parity errors and remote errors counted
      apb(1'b1, REG_EXP_TRACE, 32'h3c);
      apb(1'b1, REG_CTRL, WCH);
      clr();
      mf(3'h1, 8'h3c, 1'b0, 1'b0, 1'b0);
      mf(3'h1, 8'h3c, 1'b1, 1'b0, 1'b0);
      mf(3'h1, 8'h3c, 1'b1, 1'b0, 1'b0);
      chk("tx rei set", u_src.last_v5[5], 32'h1);
      mf(3'h1, 8'h3c, 1'b0, 1'b1, 1'b0);
      mf(3'h1, 8'h3c, 1'b0, 1'b0, 1'b0);
      chk("tx rei clear", u_src.last_v5[5], 32'h0);
      chk("clean defects", {mis, unq}, 32'h0);
      repeat (2 * SEC + 20) @(posedge sys_clk);
      chk("reports", nrep >= 2, 32'h1);
      chk("near count", sn, 32'h2);
      chk("far count", sf, 32'h1);
      chk("defect secs", {dn, df}, 32'h0);
      // wrong trace, unequipped label, remote defect
      clr();
      mf(3'h0, 8'h99, 1'b0, 1'b0, 1'b1);
      mf(3'h0, 8'h99, 1'b0, 1'b0, 1'b1);
      repeat (3) @(posedge sys_clk);
      chk("defects watched", {mis, unq}, 32'h3);
      rdc("status raw", REG_STATUS, 32'he);
      chk("tx rdi", u_src.last_v5[0], 32'h1);
      repeat (2 * SEC + 20) @(posedge sys_clk);
      chk("defect secs", {dn, df}, 32'h3);
      rdc("pm near", REG_PM_NEAR, 32'h0001_0000);
      rdc("pm far", REG_PM_FAR, 32'h0001_0000);
      // not monitored: nothing reported, raw state still seen
      apb(1'b1, REG_CTRL, 32'h0);
      mf(3'h0, 8'h99, 1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge sys_clk);
      chk("defects off", {mis, unq}, 32'h0);
      rdc("status off", REG_STATUS, 32'h6);
      clr();
      repeat (SEC + 20) @(posedge sys_clk);
      chk("no report", nrep, 32'h0);
      // short container with gaps, trace checked at its own j2 place
      apb(1'b1, REG_CTRL, V11 | WCH);
      v11 = 1'b1;
      gp = 1'b1;
      clr();
      mf(3'h1, 8'h3c, 1'b0, 1'b0, 1'b0);
      mf(3'h1, 8'h77, 1'b1, 1'b0, 1'b0);
      repeat (3) @(posedge sys_clk);
      chk("vc11 mismatch", mis, 32'h1);
      mf(3'h1, 8'h3c, 1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge sys_clk);
      chk("vc11 match", mis, 32'h0);
      repeat (2 * SEC + 20) @(posedge sys_clk);
      chk("vc11 near", sn, 32'h1);
      // one-way monitored: far end ignored, near end kept
      v11 = 1'b0;
      gp = 1'b0;
      apb(1'b1, REG_CTRL, UNI | WCH);
      mf(3'h1, 8'h3c, 1'b0, 1'b1, 1'b1);
      clr();
      mf(3'h1, 8'h3c, 1'b1, 1'b1, 1'b1);
      mf(3'h1, 8'h3c, 1'b0, 1'b1, 1'b1);
      rdc("status uni watched", REG_STATUS, 32'h1);
      repeat (2 * SEC + 20) @(posedge sys_clk);
      chk("uni far count", sf, 32'h0);
      chk("uni far second", df, 32'h0);
      chk("uni near", sn, 32'h1);
      close_out();
   end
endmodule // tb
`default_nettype wire
